// [hw/dbg_consts.svh]
`ifndef DBG_CONSTS_SVH
`define DBG_CONSTS_SVH

// processor status register numbers
`define OFS_SAVED_STATUS 8'h10
`define OFS_SAVED_PC 8'h11
`define OFS_SAVED_STACK 8'h12
`define OFS_RREAD_CORE 8'h13
`define OFS_RREAD_REG 8'h14
`define OFS_IRQ_CAUSE 8'h15
`define OFS_IRQ_PAYLOAD 8'h16
`define OFS_HALT_MASK 8'h18
`define OFS_SCRATCH_BASE 8'h20
`define OFS_BP_ADDR_BASE 8'h30
`define OFS_BP_CTRL_BASE 8'h40

// field positions
`define CAUSE_CODE_MSB 2
`define CAUSE_CORE_LSB 8
`define CAUSE_CORE_MSB 15
`define CAUSE_UNIT_LSB 16
`define CAUSE_UNIT_MSB 17
`define BPC_ENABLE_BIT 0
`define BPC_INVERT_BIT 1
`define BPC_MASK_LSB 16
`define BPC_MASK_MSB 23

// cause encodings
`define CAUSE_NONE 3'h0
`define CAUSE_HOST 3'h1
`define CAUSE_DEBUG_CALL_INSTRUCTION 3'h2
`define CAUSE_IBREAK 3'h3
`define CAUSE_DWATCH 3'h4
`define CAUSE_RWATCH 3'h5

// reset values
`define RST_WORD 32'h0000_0000
`define RST_BYTE 8'h00

`endif

// [hw/dbg_pkg.sv]
package dbg_pkg;
    // processor status access from the tile
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
        logic [31:0] wdata;
    } ps_req_t;

    // one program counter sample per issue slot
    typedef struct packed {
        logic valid;
        logic [2:0] core;
        logic [31:0] pc;
    } pc_probe_t;

    // report from the pipeline that the debug interrupt was taken
    typedef struct packed {
        logic valid;
        logic [2:0] cause;
        logic [7:0] core;
        logic [1:0] unit;
        logic [31:0] status;
        logic [31:0] pc;
        logic [31:0] sp;
        logic [31:0] data;
    } entry_t;

    // test port access to the scratch words
    typedef struct packed {
        logic valid;
        logic write;
        logic [2:0] index;
        logic [31:0] wdata;
    } host_req_t;
endpackage

// [hw/scratch_mem.sv]
`timescale 1ns/1ps
// eight shared words, two ports, registered read data
module scratch_mem (
    input wire logic core_clk,
    input wire logic a_we,
    input wire logic [2:0] a_index,
    input wire logic [31:0] a_wdata,
    output logic [31:0] a_rdata,
    input wire logic b_we,
    input wire logic [2:0] b_index,
    input wire logic [31:0] b_wdata,
    output logic [31:0] b_rdata
);
    logic [31:0] words [0:7]; // storage, not reset

    // port b (test port) wins when both write one word in a cycle
    always_ff @(posedge core_clk) begin
        if (b_we) begin
            words[b_index] <= b_wdata;
        end
        if (a_we && !(b_we && b_index == a_index)) begin
            words[a_index] <= a_wdata;
        end
    end

    // read data are registered on both ports
    always_ff @(posedge core_clk) begin
        a_rdata <= words[a_index];
        b_rdata <= words[b_index];
    end
endmodule

// [hw/core_debug_breakpoint_unit.sv]
`timescale 1ns/1ps
`include "dbg_consts.svh"
// How it works
// - capture status word on debug entry
// - capture program counter, software may rewrite
// - capture stack pointer, software may rewrite
// - remote read core number, low eight bits
// - remote read register index, five bits
// - three-bit cause code, reset zero
// - lowest firing unit number recorded
// - causing core number, else zero
// - data watchpoint loads effective address
// - resource watchpoint loads resource identifier
// - halt mask stops cores outside debug
// - eight scratch words shared with host
// - four breakpoints compare program counter
// - per-core enable mask per breakpoint
// - bit zero enables breakpoint
module core_debug_breakpoint_unit
    import dbg_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire ps_req_t ps_req,
    output logic ps_rvalid,
    output logic [31:0] ps_rdata,
    input wire host_req_t host_req,
    output logic host_rvalid,
    output logic [31:0] host_rdata,
    input wire pc_probe_t pc_probe,
    input wire logic [7:0] core_in_debug,
    input wire entry_t entry,
    output logic bp_irq,
    output logic [1:0] bp_unit,
    output logic [2:0] bp_core,
    output logic [7:0] core_halt,
    output logic [7:0] rread_core,
    output logic [4:0] rread_reg
);
    logic [31:0] saved_status; // read only copy
    logic [31:0] saved_pc;
    logic [31:0] saved_stack;
    logic [2:0] cause_code;
    logic [7:0] cause_core;
    logic [1:0] cause_unit;
    logic [31:0] payload;
    logic [7:0] halt_mask;
    logic [31:0] bp_addr [0:3];
    logic [7:0] bp_mask [0:3];
    logic [3:0] bp_en;
    logic [3:0] bp_inv;
    logic [3:0] hit; // per-unit match this cycle
    logic ps_wr; // decoded write strobe
    logic scratch_sel; // request falls in scratch window
    logic [31:0] reg_val_q; // first read stage
    logic scr_q; // first stage came from scratch
    logic rd_q; // first stage is a read
    logic [7:0] rd_addr_q; // address pipeline for checks
    logic [7:0] rd_addr_qq;
    logic [31:0] mem_rdata;
    logic [31:0] next_reg_val;

    // true when an address hits a four-deep bank at base
    function automatic logic in_bank(input logic [7:0] a, input logic [7:0] base);
        in_bank = (a[7:2] == base[7:2]);
    endfunction

    // lowest set bit of a four-bit vector
    function automatic logic [1:0] lowest(input logic [3:0] v);
        if (v[0]) begin
            lowest = 2'h0;
        end else if (v[1]) begin
            lowest = 2'h1;
        end else if (v[2]) begin
            lowest = 2'h2;
        end else begin
            lowest = 2'h3;
        end
    endfunction

    assign ps_wr = ps_req.valid && ps_req.write;
    assign scratch_sel = ps_req.addr[7:3] == 5'(`OFS_SCRATCH_BASE >> 3);

    // shared scratch words, second port belongs to the test port
    scratch_mem u_scratch (
        .core_clk(core_clk),
        .a_we(ps_wr && scratch_sel),
        .a_index(ps_req.addr[2:0]),
        .a_wdata(ps_req.wdata),
        .a_rdata(mem_rdata),
        .b_we(host_req.valid && host_req.write),
        .b_index(host_req.index),
        .b_wdata(host_req.wdata),
        .b_rdata(host_rdata)
    );

    // host read answer marks the cycle host_rdata is fresh
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            host_rvalid <= 1'b0;
        end else begin
            host_rvalid <= host_req.valid && !host_req.write;
        end
    end

    // entry capture; a capture in the same cycle as a write wins
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            saved_status <= `RST_WORD;
            saved_pc <= `RST_WORD;
            saved_stack <= `RST_WORD;
            payload <= `RST_WORD;
        end else if (entry.valid) begin
            saved_status <= entry.status;
            saved_pc <= entry.pc;
            saved_stack <= entry.sp;
            // only watchpoints leave something in the payload
            if (entry.cause == `CAUSE_DWATCH || entry.cause == `CAUSE_RWATCH) begin
                payload <= entry.data;
            end
        end else if (ps_wr) begin
            // status copy is read only, writes to it are dropped
            if (ps_req.addr == `OFS_SAVED_PC) begin
                saved_pc <= ps_req.wdata;
            end
            if (ps_req.addr == `OFS_SAVED_STACK) begin
                saved_stack <= ps_req.wdata;
            end
            if (ps_req.addr == `OFS_IRQ_PAYLOAD) begin
                payload <= ps_req.wdata;
            end
        end
    end

    // cause register; hardware capture beats a software write
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cause_code <= `CAUSE_NONE;
            cause_core <= `RST_BYTE;
            cause_unit <= 2'h0;
        end else if (entry.valid) begin
            cause_code <= entry.cause;
            // host requests have no causing core
            cause_core <= (entry.cause == `CAUSE_HOST) ? `RST_BYTE : entry.core;
            if (entry.cause == `CAUSE_IBREAK) begin
                cause_unit <= bp_unit;
            end else if (entry.cause == `CAUSE_DWATCH || entry.cause == `CAUSE_RWATCH) begin
                cause_unit <= entry.unit;
            end else begin
                cause_unit <= 2'h0;
            end
        end else if (ps_wr && ps_req.addr == `OFS_IRQ_CAUSE) begin
            cause_code <= ps_req.wdata[`CAUSE_CODE_MSB:0];
            cause_core <= ps_req.wdata[`CAUSE_CORE_MSB:`CAUSE_CORE_LSB];
            cause_unit <= ps_req.wdata[`CAUSE_UNIT_MSB:`CAUSE_UNIT_LSB];
        end
    end

    // operands of the remote register read and the halt mask
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rread_core <= `RST_BYTE;
            rread_reg <= 5'h00;
            halt_mask <= `RST_BYTE;
        end else if (ps_wr) begin
            if (ps_req.addr == `OFS_RREAD_CORE) begin
                rread_core <= ps_req.wdata[7:0];
            end
            if (ps_req.addr == `OFS_RREAD_REG) begin
                rread_reg <= ps_req.wdata[4:0];
            end
            if (ps_req.addr == `OFS_HALT_MASK) begin
                halt_mask <= ps_req.wdata[7:0];
            end
        end
    end

    // a halted core may still run debug code, so debug mode lifts the stop
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            core_halt <= `RST_BYTE;
        end else begin
            core_halt <= halt_mask & ~core_in_debug;
        end
    end

    // one address, control and compare per breakpoint
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_bp
            // registers of one breakpoint, enables reset to zero
            always_ff @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    bp_addr[gi] <= `RST_WORD;
                    bp_mask[gi] <= `RST_BYTE;
                    bp_en[gi] <= 1'b0;
                    bp_inv[gi] <= 1'b0;
                end else if (ps_wr) begin
                    if (ps_req.addr == (`OFS_BP_ADDR_BASE | 8'(gi))) begin
                        bp_addr[gi] <= ps_req.wdata;
                    end
                    if (ps_req.addr == (`OFS_BP_CTRL_BASE | 8'(gi))) begin
                        bp_mask[gi] <= ps_req.wdata[`BPC_MASK_MSB:`BPC_MASK_LSB];
                        bp_en[gi] <= ps_req.wdata[`BPC_ENABLE_BIT];
                        bp_inv[gi] <= ps_req.wdata[`BPC_INVERT_BIT];
                    end
                end
            end
            // compare; a core already in debug never matches
            assign hit[gi] = pc_probe.valid && bp_en[gi]
                && bp_mask[gi][pc_probe.core]
                && !core_in_debug[pc_probe.core]
                && ((pc_probe.pc == bp_addr[gi]) ^ bp_inv[gi]);
        end
    endgenerate

    // request to the pipeline, lowest unit wins a tie
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            bp_irq <= 1'b0;
            bp_unit <= 2'h0;
            bp_core <= 3'h0;
        end else begin
            bp_irq <= |hit;
            if (|hit) begin
                bp_unit <= lowest(hit);
                bp_core <= pc_probe.core;
            end
        end
    end

    // first read stage: pick the register value, unmapped reads give zero
    always_comb begin
        next_reg_val = `RST_WORD;
        if (ps_req.addr == `OFS_SAVED_STATUS) begin
            next_reg_val = saved_status;
        end else if (ps_req.addr == `OFS_SAVED_PC) begin
            next_reg_val = saved_pc;
        end else if (ps_req.addr == `OFS_SAVED_STACK) begin
            next_reg_val = saved_stack;
        end else if (ps_req.addr == `OFS_RREAD_CORE) begin
            next_reg_val = {24'h00_0000, rread_core};
        end else if (ps_req.addr == `OFS_RREAD_REG) begin
            next_reg_val = {27'h000_0000, rread_reg};
        end else if (ps_req.addr == `OFS_IRQ_CAUSE) begin
            next_reg_val = {14'h0000, cause_unit, cause_core, 5'h00, cause_code};
        end else if (ps_req.addr == `OFS_IRQ_PAYLOAD) begin
            next_reg_val = payload;
        end else if (ps_req.addr == `OFS_HALT_MASK) begin
            next_reg_val = {24'h00_0000, halt_mask};
        end else if (in_bank(ps_req.addr, `OFS_BP_ADDR_BASE)) begin
            next_reg_val = bp_addr[ps_req.addr[1:0]];
        end else if (in_bank(ps_req.addr, `OFS_BP_CTRL_BASE)) begin
            next_reg_val = {8'h00, bp_mask[ps_req.addr[1:0]], 14'h0000,
                bp_inv[ps_req.addr[1:0]], bp_en[ps_req.addr[1:0]]};
        end
    end

    // two-stage read so scratch and plain registers answer alike
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reg_val_q <= `RST_WORD;
            scr_q <= 1'b0;
            rd_q <= 1'b0;
            rd_addr_q <= `RST_BYTE;
            rd_addr_qq <= `RST_BYTE;
            ps_rvalid <= 1'b0;
            ps_rdata <= `RST_WORD;
        end else begin
            reg_val_q <= next_reg_val;
            scr_q <= scratch_sel;
            rd_q <= ps_req.valid && !ps_req.write;
            rd_addr_q <= ps_req.addr;
            rd_addr_qq <= rd_addr_q;
            ps_rvalid <= rd_q;
            if (rd_q) begin
                ps_rdata <= scr_q ? mem_rdata : reg_val_q;
            end
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_status_capture: assert property (entry.valid |=> saved_status == $past(entry.status))
        else $error("saved status not captured");
    a_pc_capture: assert property (entry.valid |=> saved_pc == $past(entry.pc))
        else $error("saved pc not captured");
    a_stack_capture: assert property (entry.valid |=> saved_stack == $past(entry.sp))
        else $error("saved stack not captured");
    a_core_sel_read: assert property (ps_rvalid && rd_addr_qq == `OFS_RREAD_CORE
        |-> ps_rdata == {24'h00_0000, $past(rread_core, 2)})
        else $error("core select read wrong");
    a_reg_sel_read: assert property (ps_rvalid && rd_addr_qq == `OFS_RREAD_REG
        |-> ps_rdata[31:5] == 27'h000_0000)
        else $error("register select upper bits set");
    a_cause_capture: assert property (entry.valid |=> cause_code == $past(entry.cause))
        else $error("cause not recorded");
    a_unit_lowest: assert property (hit[0] |=> bp_irq && bp_unit == 2'd0)
        else $error("lowest breakpoint not chosen");
    a_host_core_zero: assert property (entry.valid && entry.cause == `CAUSE_HOST
        |=> cause_core == `RST_BYTE)
        else $error("host cause left core number");
    a_watch_payload: assert property (entry.valid && entry.cause == `CAUSE_DWATCH
        |=> payload == $past(entry.data))
        else $error("watch address not loaded");
    a_halt_gating: assert property (core_halt
        == ($past(halt_mask) & ~$past(core_in_debug)))
        else $error("halt mask not applied");
    a_bp_no_debug: assert property (pc_probe.valid && core_in_debug[pc_probe.core]
        |=> !bp_irq)
        else $error("breakpoint in debug mode");
    a_bp_disabled: assert property (bp_en == 4'h0 |=> !bp_irq)
        else $error("disabled breakpoint fired");
    a_bp_equal: assert property (pc_probe.valid && bp_en[0] && !bp_inv[0]
        && bp_mask[0][pc_probe.core] && !core_in_debug[pc_probe.core]
        && pc_probe.pc == bp_addr[0] |=> bp_irq ##0 bp_unit == 2'd0)
        else $error("equal match missed");

    c_bp_fire: cover property (bp_irq ##1 entry.valid && entry.cause == `CAUSE_IBREAK);
    c_bp_inverted: cover property (bp_irq && bp_inv[bp_unit]);
    c_scratch_read: cover property (ps_rvalid && rd_addr_qq[7:3] == 5'h04);
    c_watch_entry: cover property (entry.valid && entry.cause == `CAUSE_RWATCH);
endmodule

// [test/dbg_host_model.sv]
`timescale 1ns/1ps
// external debugger on the test port: one scratch word per request
module dbg_host_model
    import dbg_pkg::*;
(
    input wire logic core_clk,
    output host_req_t host_req
);
    // port idle until the first access
    initial host_req = '0;

    // request held for exactly one taking edge, then released
    task automatic access(input logic wr, input logic [2:0] idx, input logic [31:0] d);
        @(posedge core_clk);
        #1 host_req = {1'b1, wr, idx, d};
        @(posedge core_clk);
        // released data is scrambled so a stale value never looks valid
        #1 host_req = {1'b0, wr, idx, ~d};
    endtask
endmodule

// [test/core_debug_breakpoint_unit_tb_top.sv]
`timescale 1ns/1ps
module core_debug_breakpoint_unit_tb_top;
    import dbg_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    ps_req_t ps_req = '0;
    pc_probe_t pc_probe = '0;
    logic [7:0] core_in_debug = 8'h00;
    entry_t entry = '0;
    host_req_t host_req;
    logic ps_rvalid, host_rvalid, bp_irq;
    logic [31:0] ps_rdata, host_rdata;
    logic [1:0] bp_unit;
    logic [2:0] bp_core;
    logic [7:0] core_halt, rread_core;
    logic [4:0] rread_reg;
    int num_errors = 0;
    int total_checks = 0;
    integer seed = 32'hc30d_c4b6;
    // expected results, oldest first
    logic [31:0] psq[$], hq[$];
    logic [4:0] bpq[$];
    logic [31:0] a, b, pl, st, pc, sp, dt;
    logic [7:0] cr;
    logic [1:0] un;
    logic [2:0] cz[4] = '{3'd1, 3'd2, 3'd4, 3'd5};

    // 20 MHz tile clock
    always #25 core_clk = ~core_clk;

    core_debug_breakpoint_unit uut (
        .core_clk(core_clk), .rst(rst), .ps_req(ps_req), .ps_rvalid(ps_rvalid),
        .ps_rdata(ps_rdata), .host_req(host_req), .host_rvalid(host_rvalid),
        .host_rdata(host_rdata), .pc_probe(pc_probe), .core_in_debug(core_in_debug),
        .entry(entry), .bp_irq(bp_irq), .bp_unit(bp_unit), .bp_core(bp_core),
        .core_halt(core_halt), .rread_core(rread_core), .rread_reg(rread_reg)
    );

    dbg_host_model u_host (.core_clk(core_clk), .host_req(host_req));

    // one comparison, counted
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one status port access, held for a single taking edge
    task ps(input logic wr, input logic [7:0] ad, input logic [31:0] d);
        @(posedge core_clk);
        #1 ps_req = {1'b1, wr, ad, d};
        @(posedge core_clk);
        #1 ps_req = {1'b0, wr, ad, ~d};
    endtask

    // read with its expected value noted first
    task rd(input logic [7:0] ad, input logic [31:0] exp);
        psq.push_back(exp);
        ps(1'b0, ad, 32'h0000_0000);
    endtask

    // pipeline reports a taken debug interrupt
    task ent(input logic [2:0] c);
        @(posedge core_clk);
        #1 entry = {1'b1, c, cr, un, st, pc, sp, dt};
        @(posedge core_clk);
        #1 entry = {1'b0, ~{c, cr, un, st, pc, sp, dt}};
    endtask

    // one program counter sample
    task prb(input logic [2:0] c, input logic [31:0] p);
        @(posedge core_clk);
        #1 pc_probe = {1'b1, c, p};
        @(posedge core_clk);
        #1 pc_probe = {1'b0, c, ~p};
    endtask

    // leftover notes mean answers that never came
    task wrap_up;
        num_errors += psq.size() + hq.size() + bpq.size();
        $display("checks=%0d errors=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // monitor: results sampled mid-cycle, an unnoted pulse forces a mismatch
    always @(negedge core_clk) begin
        if (ps_rvalid === 1'b1)
            chk(ps_rdata, psq.size() ? psq.pop_front() : ~ps_rdata);
        if (host_rvalid === 1'b1)
            chk(host_rdata, hq.size() ? hq.pop_front() : ~host_rdata);
        if (bp_irq === 1'b1)
            chk({bp_unit, bp_core}, bpq.size() ? bpq.pop_front() : ~{bp_unit, bp_core});
    end

    // watchdog well beyond the roughly 170 cycles the tests need
    initial begin
        #(50 * 4000);
        num_errors++;
        wrap_up();
    end

    initial begin
        repeat (6) @(posedge core_clk);
        #1 rst = 1'b0;
        rd(8'h15, 32'h0000_0000);
        rd(8'h40, 32'h0000_0000);
        rd(8'h17, 32'h0000_0000);
        // software rewrite of saved words, status copy stays read-only
        a = $random(seed);
        ps(1'b1, 8'h11, a);
        rd(8'h11, a);
        ps(1'b1, 8'h12, ~a);
        rd(8'h12, ~a);
        ps(1'b1, 8'h10, a);
        rd(8'h10, 32'h0000_0000);
        ps(1'b1, 8'h13, 32'hFFFF_FFFF);
        ps(1'b1, 8'h14, 32'hFFFF_FFFF);
        rd(8'h13, 32'h0000_00FF);
        rd(8'h14, 32'h0000_001F);
        chk({24'h0, rread_core}, 32'h0000_00FF);
        chk({27'h0, rread_reg}, 32'h0000_001F);
        // halt mask only holds cores that are not in debug
        ps(1'b1, 8'h18, 32'hFFFF_FFA5);
        rd(8'h18, 32'h0000_00A5);
        core_in_debug = 8'h05;
        repeat (2) @(posedge core_clk);
        #1 chk({24'h0, core_halt}, 32'h0000_00A0);
        core_in_debug = 8'h00;
        // scratch words seen from both sides
        for (int i = 0; i < 8; i++) begin
            b = $random(seed);
            ps(1'b1, 8'(8'h20 + i), b);
            hq.push_back(b);
            u_host.access(1'b0, 3'(i), 32'h0000_0000);
        end
        b = $random(seed);
        u_host.access(1'b1, 3'd5, b);
        rd(8'h25, b);
        // entry capture for every cause except breakpoint
        pl = 32'h0000_0000;
        for (int k = 0; k < 4; k++) begin
            st = $random(seed);
            pc = $random(seed);
            sp = $random(seed);
            dt = $random(seed);
            cr = 8'($random(seed));
            un = 2'($random(seed));
            ent(cz[k]);
            if (cz[k] >= 3'd4)
                pl = dt;
            rd(8'h10, st);
            rd(8'h11, pc);
            rd(8'h12, sp);
            rd(8'h15, {14'h0, (cz[k] >= 3'd4) ? un : 2'b00,
                (cz[k] == 3'd1) ? 8'h00 : cr, 5'h00, cz[k]});
            rd(8'h16, pl);
        end
        // software may rewrite the payload and every cause field
        pl = $random(seed);
        ps(1'b1, 8'h16, pl);
        rd(8'h16, pl);
        ps(1'b1, 8'h15, 32'hFFFF_FFFF);
        rd(8'h15, 32'h0003_FF07);
        // units 1 and 3 on one address, unit 0 elsewhere
        a = $random(seed);
        b = ~a;
        ps(1'b1, 8'h31, a);
        ps(1'b1, 8'h33, a);
        ps(1'b1, 8'h30, b);
        ps(1'b1, 8'h41, 32'h0004_0001);
        ps(1'b1, 8'h43, 32'h0004_0001);
        rd(8'h43, 32'h0004_0001);
        bpq.push_back(5'b01_010);
        prb(3'd2, a);
        prb(3'd3, a);
        core_in_debug = 8'h04;
        prb(3'd2, a);
        core_in_debug = 8'h00;
        ps(1'b1, 8'h40, 32'h0004_0003);
        bpq.push_back(5'b00_010);
        prb(3'd2, a);
        prb(3'd2, b);
        ps(1'b1, 8'h40, 32'h0004_0002);
        bpq.push_back(5'b01_010);
        prb(3'd2, a);
        ps(1'b1, 8'h42, 32'hFFFF_FFFF);
        rd(8'h42, 32'h00FF_0003);
        // unit 2 now watches every core and fires on any pc but zero
        bpq.push_back(5'b10_101);
        prb(3'd5, a | 32'h0000_0001);
        // breakpoint entry takes the last reported unit
        cr = 8'h02;
        ent(3'd3);
        rd(8'h15, {14'h0, 2'd2, cr, 5'h00, 3'd3});
        repeat (4) @(posedge core_clk);
        wrap_up();
    end
endmodule
